// ===== rtl/timer_h_pkg.sv
// Constants, field layout and mode codes for the 8-bit timer H channel.
// Assumes a byte-wide register port with a 32-bit address.
package timer_h_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam int ADDR_W = 32;
	localparam int DATA_W = 8;
	localparam logic [31:0] OFF_MODE = 32'hfffff580;
	localparam logic [31:0] OFF_PERIOD = 32'hfffff584;
	localparam logic [31:0] OFF_SECOND = 32'hfffff588;
	localparam logic [31:0] OFF_COUNT = 32'hfffff58c;
	localparam logic [7:0] RESET_VAL = 8'h00;

	// ****************************************************************
	// Mode register fields
	// ****************************************************************
	localparam int EN_BIT = 7;
	localparam int CKS_HI = 6;
	localparam int CKS_LO = 4;
	localparam int MODE_HI = 3;
	localparam int MODE_LO = 2;
	localparam int LEV_BIT = 1;
	localparam int GATE_BIT = 0;

	typedef enum logic [1:0] {
		MODE_INTERVAL = 2'b00,
		MODE_CARRIER = 2'b01,
		MODE_PWM = 2'b10,
		MODE_BAD = 2'b11
	} timer_mode_e;

	typedef enum logic {
		PH_PERIOD = 1'b0,
		PH_SECOND = 1'b1
	} phase_e;

	// ****************************************************************
	// Count clock selection
	// ****************************************************************
	localparam int PRESC_W = 10;
	localparam logic [2:0] CKS_DIV1 = 3'h0;
	localparam logic [2:0] CKS_DIV2 = 3'h1;
	localparam logic [2:0] CKS_DIV4 = 3'h2;
	localparam logic [2:0] CKS_DIV16 = 3'h3;
	localparam logic [2:0] CKS_DIV64 = 3'h4;
	localparam logic [2:0] CKS_DIV1024 = 3'h5;

	// Divider minus one; all ratios are powers of two
	function automatic logic [PRESC_W-1:0] div_mask(input logic [2:0] sel);
		case (sel)
			CKS_DIV1: div_mask = 10'h000;
			CKS_DIV2: div_mask = 10'h001;
			CKS_DIV4: div_mask = 10'h003;
			CKS_DIV16: div_mask = 10'h00f;
			CKS_DIV64: div_mask = 10'h03f;
			CKS_DIV1024: div_mask = 10'h3ff;
			default: div_mask = 10'h000;
		endcase
	endfunction

	function automatic logic cks_valid(input logic [2:0] sel);
		cks_valid = (sel <= CKS_DIV1024);
	endfunction

endpackage

// ===== rtl/tick_if.sv
// Link between the timer core and its count clock prescaler.
// Assumes both ends run on the one core clock.
`timescale 1ns/10ps
interface tick_if;
	logic [2:0] sel;
	logic run;
	logic tick;
	modport core (output sel, output run, input tick);
	modport presc (input sel, input run, output tick);
endinterface

// ===== rtl/count_prescaler.sv
// Count clock prescaler: one-cycle tick at the selected division.
// Assumes sel stays constant while run is high.
`timescale 1ns/10ps
module count_prescaler #(
	parameter int DIV_W = timer_h_pkg::PRESC_W
) (
	input wire logic clk_i,
	input wire logic rst_i,
	tick_if.presc link
);
	import timer_h_pkg::*;

	if (DIV_W < PRESC_W) begin : g_bad_width
		$error("Prescaler too narrow for the largest ratio");
	end

	logic [DIV_W-1:0] div_cnt;
	logic [DIV_W-1:0] next_div_cnt;

	// Restarting from zero makes the first tick come one full period after enable
	always_comb begin
		next_div_cnt = div_cnt + {{(DIV_W-1){1'b0}}, 1'b1};
		if (!link.run) begin
			next_div_cnt = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_cnt <= '0;
		end else begin
			div_cnt <= next_div_cnt;
		end
	end

	// Prohibited codes give no tick, so the counter simply stays put
	assign link.tick = link.run && cks_valid(link.sel) &&
		((div_cnt[PRESC_W-1:0] & div_mask(link.sel)) == div_mask(link.sel));

endmodule

// ===== rtl/eight_bit_timer_h_core.sv
// One channel of the 8-bit timer H: registers, counter, compares and output.
// Assumes a byte register port with read data one cycle after the strobe.
//
// What this block does
// - Period match raises interrupt, toggles output
// - Period register read/write as one byte
// - Secondary compare only in PWM, carrier
// - PWM secondary match toggles, no interrupt
// - Carrier secondary match interrupts and clears counter
// - Running secondary writes buffered until old match
// - Write colliding with reload skips that reload
// - Disabled holds counter zero; enable starts counting
// - Clock select picks divide 1..1024
// - Mode field selects interval, carrier, PWM
// - Default level and output gate control pin
// - Interval mode ignores secondary compare
// - Stop returns interrupt and output to default
`timescale 1ns/10ps
module eight_bit_timer_h_core (
	input wire logic CORE_CLK_I,
	input wire logic RESET_I,
	input wire logic [timer_h_pkg::ADDR_W-1:0] ADDR_I,
	input wire logic [timer_h_pkg::DATA_W-1:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [timer_h_pkg::DATA_W-1:0] RDATA_O,
	output logic MATCH_IRQ_O,
	output logic TIMER_OUT_O
);
	import timer_h_pkg::*;

	// ****************************************************************
	// Registers
	// ****************************************************************
	logic [7:0] mode;
	logic [7:0] period;
	logic [7:0] sec_buf;
	logic [7:0] sec_act;
	logic sec_pend;
	logic [7:0] next_mode;
	logic [7:0] next_period;
	logic [7:0] next_sec_buf;
	logic [7:0] next_sec_act;
	logic next_sec_pend;

	logic [7:0] cnt;
	logic out_lvl;
	phase_e phase;
	logic [7:0] next_cnt;
	logic next_out_lvl;
	phase_e next_phase;
	logic next_irq;
	logic next_pin;
	logic [7:0] next_rdata;

	logic en;
	logic lev;
	logic gate;
	timer_mode_e md;
	logic wr_sec;
	logic period_hit;
	logic sec_hit;

	tick_if tk ();

	count_prescaler u_presc (
		.clk_i(CORE_CLK_I),
		.rst_i(RESET_I),
		.link(tk)
	);

	assign en = mode[EN_BIT];
	assign lev = mode[LEV_BIT];
	assign gate = mode[GATE_BIT];
	assign md = timer_mode_e'(mode[MODE_HI:MODE_LO]);
	assign tk.sel = mode[CKS_HI:CKS_LO];
	assign tk.run = en;
	assign wr_sec = WR_I && (ADDR_I == OFF_SECOND);

	// Carrier mode alternates: period phase, then secondary phase
	assign period_hit = tk.tick && (cnt == period) &&
		!(md == MODE_CARRIER && phase == PH_SECOND);
	// Interval and prohibited mode never look at the secondary value
	assign sec_hit = tk.tick && (cnt == sec_act) &&
		((md == MODE_PWM) || (md == MODE_CARRIER && phase == PH_SECOND));

	// ****************************************************************
	// Register writes and secondary reload
	// ****************************************************************
	always_comb begin
		next_mode = mode;
		next_period = period;
		next_sec_buf = sec_buf;
		next_sec_act = sec_act;
		next_sec_pend = sec_pend;
		if (WR_I && ADDR_I == OFF_MODE) begin
			next_mode = WDATA_I;
		end
		if (WR_I && ADDR_I == OFF_PERIOD) begin
			next_period = WDATA_I;
		end
		// Reload only at a match with the old value, never on a colliding write
		if (sec_hit && sec_pend && !wr_sec) begin
			next_sec_act = sec_buf;
			next_sec_pend = 1'b0;
		end
		if (wr_sec) begin
			next_sec_buf = WDATA_I;
			if (en) begin
				next_sec_pend = 1'b1;
			end else begin
				next_sec_act = WDATA_I;
				next_sec_pend = 1'b0;
			end
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			mode <= RESET_VAL;
			period <= RESET_VAL;
			sec_buf <= RESET_VAL;
			sec_act <= RESET_VAL;
			sec_pend <= 1'b0;
		end else begin
			mode <= next_mode;
			period <= next_period;
			sec_buf <= next_sec_buf;
			sec_act <= next_sec_act;
			sec_pend <= next_sec_pend;
		end
	end

	// ****************************************************************
	// Counter, output level and interrupt
	// ****************************************************************
	always_comb begin
		next_cnt = cnt;
		next_out_lvl = out_lvl;
		next_phase = phase;
		next_irq = 1'b0;
		if (!en) begin
			// Level already at default simply stays there
			next_cnt = 8'h00;
			next_out_lvl = lev;
			next_phase = PH_PERIOD;
		end else if (period_hit) begin
			next_cnt = 8'h00;
			next_out_lvl = !out_lvl;
			next_irq = 1'b1;
			if (md == MODE_CARRIER) begin
				next_phase = PH_SECOND;
			end
		end else if (sec_hit) begin
			next_out_lvl = !out_lvl;
			if (md == MODE_CARRIER) begin
				next_cnt = 8'h00;
				next_irq = 1'b1;
				next_phase = PH_PERIOD;
			end else begin
				next_cnt = 8'(cnt + 8'h01);
			end
		end else if (tk.tick) begin
			next_cnt = 8'(cnt + 8'h01);
		end
		next_pin = gate ? next_out_lvl : 1'b0;
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			cnt <= 8'h00;
			out_lvl <= 1'b0;
			phase <= PH_PERIOD;
			MATCH_IRQ_O <= 1'b0;
			TIMER_OUT_O <= 1'b0;
		end else begin
			cnt <= next_cnt;
			out_lvl <= next_out_lvl;
			phase <= next_phase;
			MATCH_IRQ_O <= next_irq;
			TIMER_OUT_O <= next_pin;
		end
	end

	// ****************************************************************
	// Read data
	// ****************************************************************
	// Secondary reads the last written value, which may still be pending
	always_comb begin
		next_rdata = 8'h00;
		if (RD_I) begin
			case (ADDR_I)
				OFF_MODE: next_rdata = mode;
				OFF_PERIOD: next_rdata = period;
				OFF_SECOND: next_rdata = sec_buf;
				OFF_COUNT: next_rdata = cnt;
				default: next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			RDATA_O <= 8'h00;
		end else begin
			RDATA_O <= next_rdata;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge CORE_CLK_I);
	endclocking
	default disable iff (RESET_I);

	property p_period_irq;
		en && period_hit |=> MATCH_IRQ_O && cnt == 8'h00;
	endproperty
	a_period_irq: assert property (p_period_irq) else $error("Period match lost");

	property p_period_toggle;
		en && gate && period_hit && !WR_I |=> TIMER_OUT_O != $past(TIMER_OUT_O);
	endproperty
	a_period_toggle: assert property (p_period_toggle) else $error("No toggle");

	property p_period_rw;
		WR_I && ADDR_I == OFF_PERIOD ##1 RD_I && ADDR_I == OFF_PERIOD
			|=> RDATA_O == $past(WDATA_I, 2);
	endproperty
	a_period_rw: assert property (p_period_rw) else $error("Period readback wrong");

	property p_interval_quiet;
		en && md == MODE_INTERVAL && tk.tick && !period_hit && !WR_I
			|=> !MATCH_IRQ_O && TIMER_OUT_O == $past(TIMER_OUT_O);
	endproperty
	a_interval_quiet: assert property (p_interval_quiet) else $error("Stray match");

	property p_pwm_sec;
		en && md == MODE_PWM && sec_hit && !period_hit
			|=> !MATCH_IRQ_O && cnt == 8'($past(cnt) + 8'h01) && out_lvl != $past(out_lvl);
	endproperty
	a_pwm_sec: assert property (p_pwm_sec) else $error("PWM secondary wrong");

	property p_carrier_sec;
		en && md == MODE_CARRIER && sec_hit |=> MATCH_IRQ_O && cnt == 8'h00;
	endproperty
	a_carrier_sec: assert property (p_carrier_sec) else $error("Carrier match wrong");

	property p_reload;
		sec_hit && sec_pend && !wr_sec |=> sec_act == $past(sec_buf) && !sec_pend;
	endproperty
	a_reload: assert property (p_reload) else $error("Reload missed");

	property p_reload_skip;
		en && sec_hit && wr_sec |=> sec_act == $past(sec_act) && sec_pend;
	endproperty
	a_reload_skip: assert property (p_reload_skip) else $error("Reload not skipped");

	property p_stopped;
		!en ##1 !en |-> cnt == 8'h00 && !MATCH_IRQ_O && out_lvl == $past(lev);
	endproperty
	a_stopped: assert property (p_stopped) else $error("Stopped timer not idle");

	property p_bad_clock;
		mode[CKS_HI:CKS_LO] > CKS_DIV1024 |-> !tk.tick;
	endproperty
	a_bad_clock: assert property (p_bad_clock) else $error("Tick on bad select");

	property p_gate;
		!gate |=> !TIMER_OUT_O;
	endproperty
	a_gate: assert property (p_gate) else $error("Output not gated");

	property p_count;
		en && md == MODE_INTERVAL && tk.tick && !period_hit
			|=> cnt == 8'($past(cnt) + 8'h01);
	endproperty
	a_count: assert property (p_count) else $error("Count step wrong");

	property p_carrier_per;
		en && md == MODE_CARRIER && period_hit |=> MATCH_IRQ_O && phase == PH_SECOND;
	endproperty
	a_carrier_per: assert property (p_carrier_per) else $error("Phase wrong");

	property p_stop_pin;
		!en && gate |=> TIMER_OUT_O == $past(lev);
	endproperty
	a_stop_pin: assert property (p_stop_pin) else $error("Pin not at default");

	c_interval: cover property (en && md == MODE_INTERVAL && period_hit);
	c_pwm: cover property (en && md == MODE_PWM && sec_hit);
	c_carrier: cover property (en && md == MODE_CARRIER && sec_hit);
	c_reload: cover property (sec_hit && sec_pend && !wr_sec);
	c_skip: cover property (en && sec_hit && wr_sec);

endmodule

// ===== test/eight_bit_timer_h_core_test.sv
// Self-checking bench for the 8-bit timer H channel, with a cycle model beside it.
// Assumes the core's register map and one-cycle read latency from the timer package.
`timescale 1ns/10ps
module eight_bit_timer_h_core_test;
	import timer_h_pkg::*;
	logic clk;
	logic rst;
	logic wr;
	logic rd;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;
	logic irq;
	logic pin;
	int bad_count = 0;
	int num_checks = 0;
	int cycles = 0;
	int settle = 0;
	logic [31:0] seed = 32'hfb13f4f0;
	int div_tab[8] = '{1, 2, 4, 16, 64, 1024, 0, 0};
	logic [ADDR_W-1:0] offs[5] = '{OFF_MODE, OFF_PERIOD, OFF_SECOND, OFF_COUNT, 32'hfffff590};
	logic [7:0] m_mode = 8'h00, m_per = 8'h00, m_sec = 8'h00, m_act = 8'h00, m_pend = 8'h00;
	logic [7:0] m_cnt = 8'h00, m_rd = 8'h00;
	logic m_pv = 1'b0, m_lvl = 1'b0, m_irq = 1'b0, m_ph = 1'b0;
	logic en, tick, per_hit, sec_hit, sec_match, swr;
	logic [1:0] md;
	int m_pc = 0;
	int dv;

	eight_bit_timer_h_core eight_bit_timer_h_core_inst (
		.CORE_CLK_I(clk),
		.RESET_I(rst),
		.ADDR_I(addr),
		.WDATA_I(wdata),
		.WR_I(wr),
		.RD_I(rd),
		.RDATA_O(rdata),
		.MATCH_IRQ_O(irq),
		.TIMER_OUT_O(pin)
	);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ****************************************************************
	// Reference model, stepped on the same edge the core samples
	// ****************************************************************
	always @(posedge clk) begin
		if (rst) begin
			{m_mode, m_per, m_sec, m_act, m_pend, m_cnt, m_rd} = '0;
			{m_pv, m_lvl, m_irq, m_ph} = '0;
			m_pc = 0;
		end else begin
			en = m_mode[EN_BIT];
			md = m_mode[MODE_HI:MODE_LO];
			dv = div_tab[m_mode[CKS_HI:CKS_LO]];
			tick = en && dv != 0 && (m_pc % (dv == 0 ? 1 : dv)) == dv - 1;
			swr = wr && addr == OFF_SECOND;
			m_rd = 8'h00;
			if (rd) begin
				case (addr)
					OFF_MODE: m_rd = m_mode;
					OFF_PERIOD: m_rd = m_per;
					OFF_SECOND: m_rd = m_sec;
					OFF_COUNT: m_rd = m_cnt;
					default: m_rd = 8'h00;
				endcase
			end
			m_irq = 1'b0;
			if (!en) begin
				m_cnt = 8'h00;
				m_lvl = m_mode[LEV_BIT];
				m_ph = 1'b0;
				m_pc = 0;
			end else begin
				m_pc = m_pc + 1;
				if (tick) begin
					per_hit = (md != MODE_CARRIER || !m_ph) && m_cnt == m_per;
					sec_match = m_cnt == m_act && (md == MODE_PWM
						|| (md == MODE_CARRIER && m_ph));
					sec_hit = sec_match && !per_hit;
					if (per_hit || sec_hit) begin
						m_lvl = !m_lvl;
					end
					if (per_hit || (sec_hit && md == MODE_CARRIER)) begin
						m_irq = 1'b1;
						m_cnt = 8'h00;
					end else begin
						m_cnt = m_cnt + 8'h01;
					end
					if (md == MODE_CARRIER && (per_hit || sec_hit)) begin
						m_ph = !m_ph;
					end
					// Reload follows the secondary match even when the period match wins
					if (sec_match && m_pv && !swr) begin
						m_act = m_pend;
						m_pv = 1'b0;
					end
				end
			end
			settle = settle > 0 ? settle - 1 : 0;
			if (wr && addr == OFF_MODE) begin
				m_mode = wdata;
				settle = 3;
			end
			if (wr && addr == OFF_PERIOD) begin
				m_per = wdata;
			end
			if (swr) begin
				m_sec = wdata;
				m_pend = wdata;
				m_pv = en;
				if (!en) begin
					m_act = wdata;
				end
			end
		end
	end

	// ****************************************************************
	// Comparison and run control
	// ****************************************************************
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Pin is skipped briefly after mode writes: gate and level latency is the core's own
	always @(negedge clk) begin
		cycles++;
		if (!rst) begin
			check(rdata, m_rd);
			check({7'h00, irq}, {7'h00, m_irq});
			if (settle == 0) begin
				check({7'h00, pin}, {7'h00, m_mode[GATE_BIT] & m_lvl});
			end
		end
		if (cycles == 40000) begin
			bad_count++;
			summarize();
		end
	end

	function automatic logic [31:0] xorshift();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// ****************************************************************
	// Bus driver and scenarios
	// ****************************************************************
	task automatic bus(input logic w, input logic r, input logic [31:0] a, input logic [7:0] d);
		wr <= w;
		rd <= r;
		addr <= a;
		wdata <= d;
		@(posedge clk);
	endtask

	task automatic run(input logic [2:0] cks, input logic [1:0] mode, input int len);
		logic [31:0] r;
		logic [7:0] ctl;
		r = xorshift();
		ctl = {1'b0, cks, mode, r[1:0]};
		bus(1'b1, 1'b0, OFF_MODE, ctl);
		bus(1'b1, 1'b0, OFF_PERIOD, cks < 3'h3 ? {5'h00, r[4:2]} : {7'h00, r[2]});
		bus(1'b0, 1'b1, OFF_PERIOD, 8'h00);
		bus(1'b1, 1'b0, OFF_SECOND, {4'h0, r[8:5]});
		bus(1'b1, 1'b0, OFF_MODE, ctl | 8'h80);
		for (int i = 0; i < len; i++) begin
			r = xorshift();
			if (r[3:0] == 4'h0) begin
				bus(1'b1, 1'b0, OFF_SECOND, {4'h0, r[7:4]});
			end else if (r[3:0] == 4'h1) begin
				bus(1'b0, 1'b1, offs[r[6:4] % 5], 8'h00);
			end else begin
				bus(1'b0, 1'b0, OFF_COUNT, 8'h00);
			end
		end
		bus(1'b1, 1'b0, OFF_MODE, ctl);
		bus(1'b0, 1'b0, OFF_COUNT, 8'h00);
		repeat (4) @(posedge clk);
		bus(1'b0, 1'b1, OFF_COUNT, 8'h00);
		bus(1'b0, 1'b0, OFF_COUNT, 8'h00);
	endtask

	initial begin
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = '0;
		wdata = 8'h00;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		// Reset values, then an unmapped write that must not stick
		foreach (offs[i]) bus(1'b0, 1'b1, offs[i], 8'h00);
		bus(1'b1, 1'b0, offs[4], 8'h5a);
		bus(1'b0, 1'b1, offs[4], 8'h00);
		bus(1'b0, 1'b0, OFF_COUNT, 8'h00);
		for (int c = 0; c < 7; c++) begin
			run(c[2:0], MODE_INTERVAL, c == 5 ? 5000 : 400);
		end
		for (int m = 0; m < 4; m++) begin
			for (int k = 0; k < 3; k++) begin
				run(k[2:0], m[1:0], 600);
			end
		end
		summarize();
	end
endmodule
